// *** verilog/uart_regs_pkg.sv ***
/*
 * Constants, types and register layouts for the UART register select map.
 * Assumes a single 250 MHz clock shared with the UART core logic.
 */
package uart_regs_pkg;

  localparam logic [3:0] ADDR_HOLD    = 4'h0;
  localparam logic [3:0] ADDR_IER     = 4'h1;
  localparam logic [3:0] ADDR_IIR_FCR = 4'h2;
  localparam logic [3:0] ADDR_LCR     = 4'h3;
  localparam logic [3:0] ADDR_MCR     = 4'h4;
  localparam logic [3:0] ADDR_LSR     = 4'h5;
  localparam logic [3:0] ADDR_MSR     = 4'h6;
  localparam logic [3:0] ADDR_SPR     = 4'h7;
  localparam logic [3:0] ADDR_TRANSMIT_FIFO_LEVEL   = 4'h8;
  localparam logic [3:0] ADDR_RECEIVE_FIFO_LEVEL   = 4'h9;
  localparam logic [3:0] ADDR_GPIO_DIRECTION   = 4'ha;
  localparam logic [3:0] ADDR_GPIO_PIN_STATE = 4'hb;
  localparam logic [3:0] ADDR_IOINT   = 4'hc;
  localparam logic [3:0] ADDR_IOCTL   = 4'he;
  localparam logic [3:0] ADDR_EXTRA_FEATURES    = 4'hf;
  localparam logic [3:0] ADDR_DLL     = 4'h0;
  localparam logic [3:0] ADDR_DLH     = 4'h1;
  localparam logic [3:0] ADDR_EFR     = 4'h2;
  localparam logic [3:0] ADDR_ON_CHAR_FIRST    = 4'h4;
  localparam logic [3:0] ADDR_ON_CHAR_SECOND    = 4'h5;
  localparam logic [3:0] ADDR_OFF_CHAR_FIRST   = 4'h6;
  localparam logic [3:0] ADDR_OFF_CHAR_SECOND   = 4'h7;

  localparam logic [7:0] LCR_ENHANCED_KEY = 8'hbf;
  localparam int         LCR_DIV_ENABLE   = 7;
  localparam int         EFR_ENHANCED     = 4;
  localparam int         MCR_TCR_ENABLE   = 2;
  localparam int         FCR_FIFO_ENABLE  = 0;
  localparam int         FCR_RX_RESET     = 1;
  localparam int         FCR_TX_RESET     = 2;
  localparam logic [7:0] IER_ENH_MASK     = 8'hf0;
  localparam logic [7:0] FCR_ENH_MASK     = 8'h30;
  localparam logic [7:0] FCR_STORE_MASK   = 8'hf1;
  localparam logic [7:0] MCR_ENH_MASK     = 8'he4;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // Status presented by the UART core, same clock domain
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [5:0] iir_low;
    logic [7:0] tx_level;
    logic [7:0] rx_level;
    logic [7:0] gpio_pin_state;
  } status_t;

  // Software settings handed to the UART core
  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] enhanced_feature;
    logic [7:0] on_char_first;
    logic [7:0] on_char_second;
    logic [7:0] off_char_first;
    logic [7:0] off_char_second;
    logic [7:0] transmission_control;
    logic [7:0] trigger_level;
    logic [7:0] gpio_direction;
    logic [7:0] gpio_interrupt_enable;
    logic [7:0] gpio_control;
    logic [7:0] extra_features;
  } cfg_t;

  typedef enum logic [4:0] {
    SEL_NONE    = 5'h00,
    SEL_HOLD    = 5'h01,
    SEL_IER     = 5'h02,
    SEL_IIR_FCR = 5'h03,
    SEL_LCR     = 5'h04,
    SEL_MCR     = 5'h05,
    SEL_LSR     = 5'h06,
    SEL_MSR     = 5'h07,
    SEL_SPR     = 5'h08,
    SEL_TCR     = 5'h09,
    SEL_TLR     = 5'h0a,
    SEL_TRANSMIT_FIFO_LEVEL   = 5'h0b,
    SEL_RECEIVE_FIFO_LEVEL   = 5'h0c,
    SEL_GPIO_DIRECTION   = 5'h0d,
    SEL_GPIO_PIN_STATE = 5'h0e,
    SEL_IOINT   = 5'h0f,
    SEL_IOCTL   = 5'h10,
    SEL_EXTRA_FEATURES    = 5'h11,
    SEL_DLL     = 5'h12,
    SEL_DLH     = 5'h13,
    SEL_EFR     = 5'h14,
    SEL_ON_CHAR_FIRST    = 5'h15,
    SEL_ON_CHAR_SECOND    = 5'h16,
    SEL_OFF_CHAR_FIRST   = 5'h17,
    SEL_OFF_CHAR_SECOND   = 5'h18
  } sel_t;

endpackage

// *** verilog/uart_register_select_map.sv ***
/*
 * Register file and address decoder of a single-channel UART.
 * Assumes the host bridge and the UART core run on mclk; status inputs
 * come from same-clock logic and need no synchroniser.
 */
`timescale 1ns/10ps
module uart_register_select_map (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // Register port
  input  wire logic [3:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [7:0]                 rdata,
  // UART core side
  input  wire uart_regs_pkg::status_t status,
  output uart_regs_pkg::cfg_t        cfg,
  output logic                       rx_pop,
  output logic                       tx_push,
  output logic [7:0]                 tx_data,
  output logic                       rx_fifo_reset,
  output logic                       tx_fifo_reset
);

  logic                rst_meta_n;
  logic                rst_n;
  uart_regs_pkg::sel_t sel;
  logic                enhanced;
  logic                tcr_open;
  logic [7:0]          scratchpad;
  logic [7:0]          iir_value;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  assign enhanced  = cfg.enhanced_feature[uart_regs_pkg::EFR_ENHANCED];
  assign tcr_open  = enhanced & cfg.modem_control[uart_regs_pkg::MCR_TCR_ENABLE];
  assign iir_value = {{2{cfg.fifo_control[uart_regs_pkg::FCR_FIFO_ENABLE]}}, status.iir_low};

  // Line control stays reachable in every set, else software could never leave one
  always_comb begin
    sel = uart_regs_pkg::SEL_NONE;
    if (cfg.line_control == uart_regs_pkg::LCR_ENHANCED_KEY) begin
      if (addr == uart_regs_pkg::ADDR_DLL) begin
        sel = uart_regs_pkg::SEL_DLL;
      end else if (addr == uart_regs_pkg::ADDR_DLH) begin
        sel = uart_regs_pkg::SEL_DLH;
      end else if (addr == uart_regs_pkg::ADDR_EFR) begin
        sel = uart_regs_pkg::SEL_EFR;
      end else if (addr == uart_regs_pkg::ADDR_LCR) begin
        sel = uart_regs_pkg::SEL_LCR;
      end else if (addr == uart_regs_pkg::ADDR_ON_CHAR_FIRST) begin
        sel = uart_regs_pkg::SEL_ON_CHAR_FIRST;
      end else if (addr == uart_regs_pkg::ADDR_ON_CHAR_SECOND) begin
        sel = uart_regs_pkg::SEL_ON_CHAR_SECOND;
      end else if (addr == uart_regs_pkg::ADDR_OFF_CHAR_FIRST) begin
        sel = uart_regs_pkg::SEL_OFF_CHAR_FIRST;
      end else if (addr == uart_regs_pkg::ADDR_OFF_CHAR_SECOND) begin
        sel = uart_regs_pkg::SEL_OFF_CHAR_SECOND;
      end
    end else if (cfg.line_control[uart_regs_pkg::LCR_DIV_ENABLE]) begin
      if (addr == uart_regs_pkg::ADDR_DLL) begin
        sel = uart_regs_pkg::SEL_DLL;
      end else if (addr == uart_regs_pkg::ADDR_DLH) begin
        sel = uart_regs_pkg::SEL_DLH;
      end else if (addr == uart_regs_pkg::ADDR_LCR) begin
        sel = uart_regs_pkg::SEL_LCR;
      end
    end else begin
      if (addr == uart_regs_pkg::ADDR_HOLD) begin
        sel = uart_regs_pkg::SEL_HOLD;
      end else if (addr == uart_regs_pkg::ADDR_IER) begin
        sel = uart_regs_pkg::SEL_IER;
      end else if (addr == uart_regs_pkg::ADDR_IIR_FCR) begin
        sel = uart_regs_pkg::SEL_IIR_FCR;
      end else if (addr == uart_regs_pkg::ADDR_LCR) begin
        sel = uart_regs_pkg::SEL_LCR;
      end else if (addr == uart_regs_pkg::ADDR_MCR) begin
        sel = uart_regs_pkg::SEL_MCR;
      end else if (addr == uart_regs_pkg::ADDR_LSR) begin
        sel = uart_regs_pkg::SEL_LSR;
      end else if (addr == uart_regs_pkg::ADDR_MSR) begin
        sel = tcr_open ? uart_regs_pkg::SEL_TCR : uart_regs_pkg::SEL_MSR;
      end else if (addr == uart_regs_pkg::ADDR_SPR) begin
        sel = tcr_open ? uart_regs_pkg::SEL_TLR : uart_regs_pkg::SEL_SPR;
      end else if (addr == uart_regs_pkg::ADDR_TRANSMIT_FIFO_LEVEL) begin
        sel = uart_regs_pkg::SEL_TRANSMIT_FIFO_LEVEL;
      end else if (addr == uart_regs_pkg::ADDR_RECEIVE_FIFO_LEVEL) begin
        sel = uart_regs_pkg::SEL_RECEIVE_FIFO_LEVEL;
      end else if (addr == uart_regs_pkg::ADDR_GPIO_DIRECTION) begin
        sel = uart_regs_pkg::SEL_GPIO_DIRECTION;
      end else if (addr == uart_regs_pkg::ADDR_GPIO_PIN_STATE) begin
        sel = uart_regs_pkg::SEL_GPIO_PIN_STATE;
      end else if (addr == uart_regs_pkg::ADDR_IOINT) begin
        sel = uart_regs_pkg::SEL_IOINT;
      end else if (addr == uart_regs_pkg::ADDR_IOCTL) begin
        sel = uart_regs_pkg::SEL_IOCTL;
      end else if (addr == uart_regs_pkg::ADDR_EXTRA_FEATURES) begin
        sel = uart_regs_pkg::SEL_EXTRA_FEATURES;
      end
    end
  end

  // Software-written settings; read-only and unselected targets fall to default
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg        <= '0;
      scratchpad <= uart_regs_pkg::REG_RESET;
    end else if (wr) begin
      case (sel)
        uart_regs_pkg::SEL_IER: begin
          cfg.interrupt_enable <= enhanced ? wdata :
            ((wdata & ~uart_regs_pkg::IER_ENH_MASK) | (cfg.interrupt_enable & uart_regs_pkg::IER_ENH_MASK));
        end
        uart_regs_pkg::SEL_IIR_FCR: begin
          cfg.fifo_control <= uart_regs_pkg::FCR_STORE_MASK & (enhanced ? wdata :
            ((wdata & ~uart_regs_pkg::FCR_ENH_MASK) | (cfg.fifo_control & uart_regs_pkg::FCR_ENH_MASK)));
        end
        uart_regs_pkg::SEL_LCR: begin
          cfg.line_control <= wdata;
        end
        uart_regs_pkg::SEL_MCR: begin
          cfg.modem_control <= enhanced ? wdata :
            ((wdata & ~uart_regs_pkg::MCR_ENH_MASK) | (cfg.modem_control & uart_regs_pkg::MCR_ENH_MASK));
        end
        uart_regs_pkg::SEL_SPR: begin
          scratchpad <= wdata;
        end
        uart_regs_pkg::SEL_TCR: begin
          cfg.transmission_control <= wdata;
        end
        uart_regs_pkg::SEL_TLR: begin
          cfg.trigger_level <= wdata;
        end
        uart_regs_pkg::SEL_GPIO_DIRECTION: begin
          cfg.gpio_direction <= wdata;
        end
        uart_regs_pkg::SEL_IOINT: begin
          cfg.gpio_interrupt_enable <= wdata;
        end
        uart_regs_pkg::SEL_IOCTL: begin
          cfg.gpio_control <= wdata;
        end
        uart_regs_pkg::SEL_EXTRA_FEATURES: begin
          cfg.extra_features <= wdata;
        end
        uart_regs_pkg::SEL_DLL: begin
          cfg.divisor_low <= wdata;
        end
        uart_regs_pkg::SEL_DLH: begin
          cfg.divisor_high <= wdata;
        end
        uart_regs_pkg::SEL_EFR: begin
          cfg.enhanced_feature <= wdata;
        end
        uart_regs_pkg::SEL_ON_CHAR_FIRST: begin
          cfg.on_char_first <= wdata;
        end
        uart_regs_pkg::SEL_ON_CHAR_SECOND: begin
          cfg.on_char_second <= wdata;
        end
        uart_regs_pkg::SEL_OFF_CHAR_FIRST: begin
          cfg.off_char_first <= wdata;
        end
        uart_regs_pkg::SEL_OFF_CHAR_SECOND: begin
          cfg.off_char_second <= wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Side-effect pulses, one cycle, aligned with the read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_pop        <= 1'b0;
      tx_push       <= 1'b0;
      tx_data       <= uart_regs_pkg::REG_RESET;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end else begin
      rx_pop        <= rd && sel == uart_regs_pkg::SEL_HOLD;
      tx_push       <= wr && sel == uart_regs_pkg::SEL_HOLD;
      rx_fifo_reset <= wr && sel == uart_regs_pkg::SEL_IIR_FCR && wdata[uart_regs_pkg::FCR_RX_RESET];
      tx_fifo_reset <= wr && sel == uart_regs_pkg::SEL_IIR_FCR && wdata[uart_regs_pkg::FCR_TX_RESET];
      if (wr && sel == uart_regs_pkg::SEL_HOLD) begin
        tx_data <= wdata;
      end
    end
  end

  // Read data; unselected offsets and idle cycles return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= uart_regs_pkg::REG_RESET;
    end else if (!rd) begin
      rdata <= uart_regs_pkg::REG_RESET;
    end else begin
      case (sel)
        uart_regs_pkg::SEL_HOLD:    rdata <= status.rx_data;
        uart_regs_pkg::SEL_IER:     rdata <= cfg.interrupt_enable;
        uart_regs_pkg::SEL_IIR_FCR: rdata <= iir_value;
        uart_regs_pkg::SEL_LCR:     rdata <= cfg.line_control;
        uart_regs_pkg::SEL_MCR:     rdata <= cfg.modem_control;
        uart_regs_pkg::SEL_LSR:     rdata <= status.line_status;
        uart_regs_pkg::SEL_MSR:     rdata <= status.modem_status;
        uart_regs_pkg::SEL_SPR:     rdata <= scratchpad;
        uart_regs_pkg::SEL_TCR:     rdata <= cfg.transmission_control;
        uart_regs_pkg::SEL_TLR:     rdata <= cfg.trigger_level;
        uart_regs_pkg::SEL_TRANSMIT_FIFO_LEVEL:   rdata <= status.tx_level;
        uart_regs_pkg::SEL_RECEIVE_FIFO_LEVEL:   rdata <= status.rx_level;
        uart_regs_pkg::SEL_GPIO_DIRECTION:   rdata <= cfg.gpio_direction;
        uart_regs_pkg::SEL_GPIO_PIN_STATE: rdata <= status.gpio_pin_state;
        uart_regs_pkg::SEL_IOINT:   rdata <= cfg.gpio_interrupt_enable;
        uart_regs_pkg::SEL_IOCTL:   rdata <= cfg.gpio_control;
        uart_regs_pkg::SEL_EXTRA_FEATURES:    rdata <= cfg.extra_features;
        uart_regs_pkg::SEL_DLL:     rdata <= cfg.divisor_low;
        uart_regs_pkg::SEL_DLH:     rdata <= cfg.divisor_high;
        uart_regs_pkg::SEL_EFR:     rdata <= cfg.enhanced_feature;
        uart_regs_pkg::SEL_ON_CHAR_FIRST:    rdata <= cfg.on_char_first;
        uart_regs_pkg::SEL_ON_CHAR_SECOND:    rdata <= cfg.on_char_second;
        uart_regs_pkg::SEL_OFF_CHAR_FIRST:   rdata <= cfg.off_char_first;
        uart_regs_pkg::SEL_OFF_CHAR_SECOND:   rdata <= cfg.off_char_second;
        default:                    rdata <= uart_regs_pkg::REG_RESET;
      endcase
    end
  end

  // Checks
  logic general;
  assign general = !cfg.line_control[uart_regs_pkg::LCR_DIV_ENABLE];

  sequence s_hold_read;
    rd && general && addr == uart_regs_pkg::ADDR_HOLD;
  endsequence

  sequence s_fcr_rx_reset;
    wr && general && addr == uart_regs_pkg::ADDR_IIR_FCR && wdata[uart_regs_pkg::FCR_RX_RESET];
  endsequence

  property p_hold_read;
    @(posedge mclk) disable iff (!rst_n)
    s_hold_read |=> rx_pop && !tx_push && rdata == $past(status.rx_data);
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("receive read did not pop");

  property p_hold_write;
    @(posedge mclk) disable iff (!rst_n)
    wr && general && addr == uart_regs_pkg::ADDR_HOLD |=> tx_push && tx_data == $past(wdata) ##1 (!tx_push || $past(wr));
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("transmit write not pushed once");

  property p_iir_read;
    @(posedge mclk) disable iff (!rst_n)
    rd && general && addr == uart_regs_pkg::ADDR_IIR_FCR
      |=> rdata == {{2{cfg.fifo_control[0]}}, $past(status.iir_low)};
  endproperty
  a_iir_read: assert property (p_iir_read) else $error("identification read wrong");

  property p_mcr_top_locked;
    @(posedge mclk) disable iff (!rst_n)
    !enhanced |=> $stable(cfg.modem_control[7]);
  endproperty
  a_mcr_top_locked: assert property (p_mcr_top_locked) else $error("modem control bit 7 changed");

  property p_tcr_hidden;
    @(posedge mclk) disable iff (!rst_n)
    rd && general && !tcr_open && addr == uart_regs_pkg::ADDR_MSR |=> rdata == $past(status.modem_status);
  endproperty
  a_tcr_hidden: assert property (p_tcr_hidden) else $error("modem status not selected");

  property p_divisor_write;
    @(posedge mclk) disable iff (!rst_n)
    wr && !general && addr == uart_regs_pkg::ADDR_DLL |=> cfg.divisor_low == $past(wdata) && !tx_push;
  endproperty
  a_divisor_write: assert property (p_divisor_write) else $error("divisor low not written");

  property p_efr_gate;
    @(posedge mclk) disable iff (!rst_n)
    cfg.line_control != uart_regs_pkg::LCR_ENHANCED_KEY |=> $stable(cfg.enhanced_feature);
  endproperty
  a_efr_gate: assert property (p_efr_gate) else $error("enhanced feature changed while locked");

  property p_readonly_write;
    @(posedge mclk) disable iff (!rst_n)
    wr && general && addr == uart_regs_pkg::ADDR_TRANSMIT_FIFO_LEVEL |=> $stable(cfg) && $stable(scratchpad);
  endproperty
  a_readonly_write: assert property (p_readonly_write) else $error("read-only write changed state");

  property p_fcr_pulse;
    @(posedge mclk) disable iff (!rst_n)
    s_fcr_rx_reset ##1 !wr |=> rx_fifo_reset == 1'b0 && $past(rx_fifo_reset);
  endproperty
  a_fcr_pulse: assert property (p_fcr_pulse) else $error("receive FIFO reset not one cycle");

  property p_ier_enhanced;
    @(posedge mclk) disable iff (!rst_n)
    wr && general && !enhanced && addr == uart_regs_pkg::ADDR_IER
      |=> cfg.interrupt_enable[7:4] == $past(cfg.interrupt_enable[7:4]) && cfg.interrupt_enable[3:0] == $past(wdata[3:0]);
  endproperty
  a_ier_enhanced: assert property (p_ier_enhanced) else $error("interrupt enable gating wrong");

  property p_scratch_write;
    @(posedge mclk) disable iff (!rst_n)
    wr && general && !tcr_open && addr == uart_regs_pkg::ADDR_SPR |=> scratchpad == $past(wdata) && $stable(cfg);
  endproperty
  a_scratch_write: assert property (p_scratch_write) else $error("scratchpad write wrong");

  property p_general_hidden;
    @(posedge mclk) disable iff (!rst_n)
    rd && !general && cfg.line_control != uart_regs_pkg::LCR_ENHANCED_KEY && addr == uart_regs_pkg::ADDR_SPR
      |=> rdata == uart_regs_pkg::REG_RESET;
  endproperty
  a_general_hidden: assert property (p_general_hidden) else $error("general register seen in divisor set");

  property p_tcr_write;
    @(posedge mclk) disable iff (!rst_n)
    wr && general && tcr_open && addr == uart_regs_pkg::ADDR_MSR |=> cfg.transmission_control == $past(wdata);
  endproperty
  a_tcr_write: assert property (p_tcr_write) else $error("transmission control not written");

  property p_lcr_write;
    @(posedge mclk) disable iff (!rst_n)
    wr && addr == uart_regs_pkg::ADDR_LCR |=> cfg.line_control == $past(wdata);
  endproperty
  a_lcr_write: assert property (p_lcr_write) else $error("line control not written");

  property p_flow_char;
    @(posedge mclk) disable iff (!rst_n)
    wr && cfg.line_control == uart_regs_pkg::LCR_ENHANCED_KEY && addr == uart_regs_pkg::ADDR_ON_CHAR_FIRST
      |=> cfg.on_char_first == $past(wdata);
  endproperty
  a_flow_char: assert property (p_flow_char) else $error("flow character not written");

  property p_ier_readback;
    @(posedge mclk) disable iff (!rst_n)
    rd && general && addr == uart_regs_pkg::ADDR_IER |=> rdata == $past(cfg.interrupt_enable);
  endproperty
  a_ier_readback: assert property (p_ier_readback) else $error("interrupt enable read wrong");

endmodule // uart_register_select_map

// *** bench/uart_core_model.sv ***
/*
 * Behavioural stand-in for the UART core behind the register map.
 * Assumes the same mclk and nrst as the register map; status is fixed except
 * for the received byte, which advances on every pop.
 */
`timescale 1ns/10ps
module uart_core_model (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // Register map side
  input  wire logic                   rx_pop,
  input  wire logic                   tx_push,
  input  wire logic [7:0]             tx_data,
  output uart_regs_pkg::status_t      status,
  output logic [7:0]                  last_tx
);
  logic [7:0] rx_byte;

  // Distinct value per field so a wrong select shows up in read data
  assign status = '{rx_data: rx_byte, line_status: 8'h61, modem_status: 8'hb5, iir_low: 6'h0c,
                    tx_level: 8'h40, rx_level: 8'h03, gpio_pin_state: 8'h5a};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rx_byte <= 8'h41;
    else if (rx_pop) rx_byte <= rx_byte + 8'h01;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) last_tx <= 8'h00;
    else if (tx_push) last_tx <= tx_data;
  end
endmodule // uart_core_model

// *** bench/tb_uart_register_select_map.sv ***
/*
 * Self-checking bench for the UART register select map.
 * Assumes the core model of uart_core_model.sv; one task per scenario.
 */
`timescale 1ns/10ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: %s", $time, m); end end
module tb_uart_register_select_map;
  logic                   mclk;
  logic                   nrst;
  logic [3:0]             addr;
  logic [7:0]             wdata;
  logic                   wr;
  logic                   rd;
  logic [7:0]             rdata;
  uart_regs_pkg::status_t status;
  uart_regs_pkg::cfg_t    cfg;
  logic                   rx_pop;
  logic                   tx_push;
  logic [7:0]             tx_data;
  logic                   rx_fifo_reset;
  logic                   tx_fifo_reset;
  logic [7:0]             last_tx;
  int                     num_errors = 0;
  int                     comparisons = 0;
  int                     cycles = 0;

  uart_register_select_map uart_register_select_map_inst (.mclk(mclk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .status(status), .cfg(cfg), .rx_pop(rx_pop),
    .tx_push(tx_push), .tx_data(tx_data), .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset));
  uart_core_model uart_core_model_inst (.mclk(mclk), .nrst(nrst), .rx_pop(rx_pop), .tx_push(tx_push),
    .tx_data(tx_data), .status(status), .last_tx(last_tx));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, far above the roughly 150 cycles the scenarios need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  // Strobe for one cycle; returns just after the taking edge has settled
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e, m)
  endtask

  task automatic s_reset();
    `CHK(cfg, uart_regs_pkg::cfg_t'(0), "cfg after reset")
    rd_chk(4'h3, 8'h00, "line control reset");
    rd_chk(4'h1, 8'h00, "interrupt enable reset");
    rd_chk(4'h4, 8'h00, "modem control reset");
  endtask

  task automatic s_general();
    wr_reg(4'h7, 8'ha5);
    rd_chk(4'h7, 8'ha5, "scratchpad");
    `CHK(cfg, uart_regs_pkg::cfg_t'(0), "scratchpad touched cfg")
    wr_reg(4'h1, 8'hff);
    rd_chk(4'h1, 8'h0f, "interrupt enable upper bits locked");
    wr_reg(4'h4, 8'hf7);
    rd_chk(4'h4, 8'h13, "modem control enhanced bits locked");
    for (int i = 10; i < 16; i++) wr_reg(4'(i), 8'(8'h20 + i));
    rd_chk(4'ha, 8'h2a, "gpio direction");
    rd_chk(4'hb, 8'h5a, "gpio pin state kept");
    rd_chk(4'hc, 8'h2c, "gpio interrupt enable");
    rd_chk(4'hd, 8'h00, "unmapped offset");
    rd_chk(4'he, 8'h2e, "gpio control");
    rd_chk(4'hf, 8'h2f, "extra features");
  endtask

  task automatic s_hold();
    rd_chk(4'h0, 8'h41, "first received byte");
    `CHK(rx_pop, 1'b1, "pop pulse")
    @(posedge mclk);
    #1;
    `CHK(rx_pop, 1'b0, "pop one cycle")
    `CHK(rdata, 8'h00, "read data one cycle")
    rd_chk(4'h0, 8'h42, "second received byte");
    wr_reg(4'h0, 8'h5e);
    `CHK(tx_push, 1'b1, "push pulse")
    `CHK(tx_data, 8'h5e, "transmit byte")
    @(posedge mclk);
    #1;
    `CHK(last_tx, 8'h5e, "core got byte")
    `CHK(tx_push, 1'b0, "push one cycle")
  endtask

  task automatic s_fifo();
    wr_reg(4'h2, 8'hf7);
    `CHK({rx_fifo_reset, tx_fifo_reset}, 2'b11, "fifo reset pulses")
    `CHK(cfg.fifo_control, 8'hc1, "fifo control stored bits")
    rd_chk(4'h2, 8'hcc, "identification with fifo mirror");
    `CHK({rx_fifo_reset, tx_fifo_reset}, 2'b00, "fifo resets cleared")
  endtask

  task automatic s_readonly();
    logic [3:0] ra[5] = '{4'h5, 4'h6, 4'h8, 4'h9, 4'hb};
    logic [7:0] re[5] = '{8'h61, 8'hb5, 8'h40, 8'h03, 8'h5a};
    for (int i = 0; i < 5; i++) begin
      wr_reg(ra[i], 8'hff);
      rd_chk(ra[i], re[i], "read-only location");
    end
    `CHK(cfg.interrupt_enable, 8'h0f, "no side effect ier")
    `CHK(cfg.modem_control, 8'h13, "no side effect mcr")
  endtask

  task automatic s_divisor();
    wr_reg(4'h3, 8'h80);
    wr_reg(4'h0, 8'h34);
    `CHK(tx_push, 1'b0, "no push while divisor open")
    wr_reg(4'h1, 8'h12);
    wr_reg(4'h7, 8'hee);
    rd_chk(4'h0, 8'h34, "divisor low");
    `CHK(rx_pop, 1'b0, "no pop while divisor open")
    rd_chk(4'h1, 8'h12, "divisor high");
    rd_chk(4'h7, 8'h00, "general hidden");
    `CHK(cfg.interrupt_enable, 8'h0f, "ier untouched")
    wr_reg(4'h3, 8'h03);
    rd_chk(4'h7, 8'ha5, "scratchpad kept");
    rd_chk(4'h3, 8'h03, "line control");
    `CHK({cfg.divisor_high, cfg.divisor_low}, 16'h1234, "divisor cfg")
  endtask

  task automatic s_enhanced();
    wr_reg(4'h3, 8'hbf);
    wr_reg(4'h2, 8'h10);
    for (int i = 4; i < 8; i++) wr_reg(4'(i), 8'(8'h0d + i));
    rd_chk(4'h2, 8'h10, "enhanced feature");
    for (int i = 4; i < 8; i++) rd_chk(4'(i), 8'(8'h0d + i), "flow characters");
    `CHK(cfg.fifo_control, 8'hc1, "fifo control untouched")
    wr_reg(4'h3, 8'hbe);
    rd_chk(4'h2, 8'h00, "enhanced hidden off key");
    wr_reg(4'h3, 8'h00);
    wr_reg(4'h4, 8'hf7);
    rd_chk(4'h4, 8'hf7, "modem control full");
    wr_reg(4'h1, 8'hf5);
    rd_chk(4'h1, 8'hf5, "interrupt enable full");
    wr_reg(4'h6, 8'h9a);
    wr_reg(4'h7, 8'h3c);
    rd_chk(4'h6, 8'h9a, "transmission control");
    rd_chk(4'h7, 8'h3c, "trigger level");
    `CHK(cfg.transmission_control, 8'h9a, "tcr cfg")
    wr_reg(4'h4, 8'hf3);
    rd_chk(4'h6, 8'hb5, "modem status back");
    rd_chk(4'h7, 8'ha5, "scratchpad back");
  endtask

  initial begin
    nrst = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    s_reset();
    s_general();
    s_hold();
    s_fifo();
    s_readonly();
    s_divisor();
    s_enhanced();
    close_out();
  end
endmodule // tb_uart_register_select_map
